//--- rcr_regs.sv
/*
 * rcr_regs: control registers for converter five, converter six and linear
 * regulator two, with sleep and force-off decoding for each rail.
 * Assumes the serial front end presents one-cycle write strobes on clk_i and
 * that sleep pins and pin enables come asynchronously from outside.
 */
// Contract
// - registers at 26h, 27h, 28h, eight bits
// - sleep field 00 uses normal code
// - field 11, sleep pin low selects sleep
// - each rail's sleep from one factory pin
// - converter mode bit 1: auto 0, PWM 1
// - bit 0 at 0 forces rail off
// - force-off same for converter six, regulator two
// - reset loads factory variant values
// - sleep code from separate seven-bit field
`timescale 1ns/1ps
`default_nettype none
module rcr_regs
	import rcr_pkg::*;
#(
	parameter logic [7:0] RST_CONV5 = RCR_RST_CONV5,
	parameter logic [7:0] RST_CONV6 = RCR_RST_CONV6,
	parameter logic [7:0] RST_LREG2 = RCR_RST_LREG2,
	parameter logic [RCR_NREG-1:0] SLEEP_PIN_SEL = 3'h0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire rcr_req_t req_i,
	input wire logic [RCR_AW-1:0] raddr_i,
	output logic [RCR_DW-1:0] rdata_o,
	input wire logic sleep_input_one_n_i,
	input wire logic sleep_input_two_n_i,
	input wire logic [RCR_NREG-1:0] pin_enable_i,
	input wire rcr_vcodes_t [RCR_NREG-1:0] vcodes_i,
	output logic [RCR_NREG-1:0] rail_on_o,
	output logic [RCR_NREG-1:0] forced_pwm_o,
	output logic [RCR_NREG-1:0] use_sleep_o,
	output logic [RCR_NREG-1:0][RCR_VCODE_W-1:0] vcode_o
);
	typedef struct packed {
		logic [RCR_NREG-1:0][RCR_DW-1:0] ctrl;
		logic [1:0] slp_meta;
		logic [1:0] slp_sync;
		logic [RCR_NREG-1:0] en_meta;
		logic [RCR_NREG-1:0] en_sync;
		logic [RCR_DW-1:0] rdata;
	} rcr_state_t;

	rcr_state_t state_ff;
	rcr_state_t nxt_state;

	function automatic int reg_index(input logic [RCR_AW-1:0] a);
		unique case (a)
			RCR_OFS_CONV5: reg_index = 0;
			RCR_OFS_CONV6: reg_index = 1;
			RCR_OFS_LREG2: reg_index = 2;
			default: reg_index = -1;
		endcase
	endfunction : reg_index

	// a reset byte must keep bits 7:6 clear and carry a defined sleep code
	function automatic bit rst_legal(input logic [RCR_DW-1:0] v);
		logic [1:0] slp;
		slp = v[RCR_SLP_HI:RCR_SLP_LO];
		rst_legal = ((v & ~RCR_WMASK) == '0) && (slp == RCR_SLP_OFF || slp == RCR_SLP_ON);
	endfunction : rst_legal

	// the decoder serves exactly three registers
	if (RCR_NREG != 3) begin : g_bad_nreg
		$error("register bank decodes exactly three registers");
	end
	if (!rst_legal(RST_CONV5) || !rst_legal(RST_CONV6) || !rst_legal(RST_LREG2)) begin : g_rst
		$error("reset value with reserved sleep code or upper bits set");
	end

	localparam logic [RCR_NREG-1:0][RCR_DW-1:0] RST_VALS = {RST_LREG2, RST_CONV6, RST_CONV5};

	always_comb begin
		int wi;
		int ri;
		wi = reg_index(req_i.addr);
		ri = reg_index(raddr_i);
		nxt_state = state_ff;
		nxt_state.slp_meta = {sleep_input_two_n_i, sleep_input_one_n_i};
		nxt_state.slp_sync = state_ff.slp_meta;
		nxt_state.en_meta = pin_enable_i;
		nxt_state.en_sync = state_ff.en_meta;
		if (req_i.we && wi >= 0) begin
			nxt_state.ctrl[wi] = req_i.wdata & RCR_WMASK;
		end
		nxt_state.rdata = (ri >= 0) ? state_ff.ctrl[ri] : '0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= '0;
			state_ff.ctrl <= RST_VALS & {RCR_NREG{RCR_WMASK}};
			state_ff.slp_meta <= 2'h3;
			state_ff.slp_sync <= 2'h3;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rdata_o = state_ff.rdata;

	for (genvar g = 0; g < RCR_NREG; g++) begin : g_rail
		rcr_rail_sel #(
			.HAS_MODE(g < 2)
		) u_sel (
			.ctrl_i(state_ff.ctrl[g]),
			.sleep_n_i(state_ff.slp_sync[SLEEP_PIN_SEL[g]]),
			.pin_enable_i(state_ff.en_sync[g]),
			.vcodes_i(vcodes_i[g]),
			.rail_on_o(rail_on_o[g]),
			.forced_pwm_o(forced_pwm_o[g]),
			.use_sleep_o(use_sleep_o[g]),
			.vcode_o(vcode_o[g])
		);
	end

	// rail enable against force-off bits and synchronised pins
	chk_off_forced: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!state_ff.ctrl[1][RCR_BIT_FORCE_OFF_N] |-> !rail_on_o[1])
		else $error("converter six on while forced off");
	chk_lreg_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!state_ff.ctrl[2][RCR_BIT_FORCE_OFF_N] |-> !rail_on_o[2])
		else $error("regulator two on while forced off");
	chk_conv5_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!state_ff.ctrl[0][RCR_BIT_FORCE_OFF_N] |-> !rail_on_o[0])
		else $error("converter five on while forced off");
	chk_pin_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!state_ff.en_sync[0] |-> !rail_on_o[0])
		else $error("converter five on without pin enable");
	chk_pin_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_ff.ctrl[0][RCR_BIT_FORCE_OFF_N] && pin_enable_i[0]) [*3] |-> rail_on_o[0])
		else $error("enabled rail stays off");
	chk_lreg_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_ff.ctrl[2][RCR_BIT_FORCE_OFF_N] && pin_enable_i[2]) [*3] |-> rail_on_o[2])
		else $error("enabled regulator stays off");

	// sleep field and voltage code selection
	chk_slp_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff.ctrl[0][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_OFF |-> !use_sleep_o[0])
		else $error("sleep used with field 00");
	chk_slp_off_six: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff.ctrl[1][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_OFF |-> !use_sleep_o[1])
		else $error("converter six sleep used with field 00");
	chk_slp_off_lreg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff.ctrl[2][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_OFF |-> !use_sleep_o[2])
		else $error("regulator two sleep used with field 00");
	chk_slp_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff.ctrl[0][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_ON
		&& !state_ff.slp_sync[SLEEP_PIN_SEL[0]] |-> use_sleep_o[0]
		&& vcode_o[0] == vcodes_i[0].sleep_vcode)
		else $error("sleep code not selected");
	chk_slp_six: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff.ctrl[1][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_ON
		&& !state_ff.slp_sync[SLEEP_PIN_SEL[1]] |-> use_sleep_o[1]
		&& vcode_o[1] == vcodes_i[1].sleep_vcode)
		else $error("converter six sleep code not selected");
	chk_slp_lreg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff.ctrl[2][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_ON
		&& !state_ff.slp_sync[SLEEP_PIN_SEL[2]] |-> use_sleep_o[2]
		&& vcode_o[2] == vcodes_i[2].sleep_vcode)
		else $error("regulator two sleep code not selected");
	chk_normal_five: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!use_sleep_o[0] |-> vcode_o[0] == vcodes_i[0].normal_vcode)
		else $error("converter five normal code not selected");
	chk_normal_six: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!use_sleep_o[1] |-> vcode_o[1] == vcodes_i[1].normal_vcode)
		else $error("converter six normal code not selected");
	chk_normal_lreg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!use_sleep_o[2] |-> vcode_o[2] == vcodes_i[2].normal_vcode)
		else $error("regulator two normal code not selected");
	chk_sleep_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_ff.ctrl[0][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_ON
		&& !(SLEEP_PIN_SEL[0] ? sleep_input_two_n_i : sleep_input_one_n_i)) [*3]
		|-> use_sleep_o[0])
		else $error("assigned sleep pin not followed");

	// converter operating mode
	chk_pwm_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		forced_pwm_o[0] == state_ff.ctrl[0][RCR_BIT_OP_MODE] && !forced_pwm_o[2])
		else $error("mode bit mismatch");
	chk_pwm_six: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		forced_pwm_o[1] == state_ff.ctrl[1][RCR_BIT_OP_MODE])
		else $error("converter six mode bit mismatch");

	// register port: decode, masking and read data
	chk_write_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i.we && req_i.addr == RCR_OFS_CONV6 |=> state_ff.ctrl[1]
		== ($past(req_i.wdata) & RCR_WMASK))
		else $error("converter six write lost");
	chk_unmap_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i.we && req_i.addr != RCR_OFS_CONV5 && req_i.addr != RCR_OFS_CONV6
		&& req_i.addr != RCR_OFS_LREG2 |=> $stable(state_ff.ctrl))
		else $error("unmapped write changed a register");
	chk_read_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		raddr_i == RCR_OFS_CONV6 |=> rdata_o == $past(state_ff.ctrl[1]))
		else $error("converter six read data wrong");
	chk_read_unmap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		raddr_i != RCR_OFS_CONV5 && raddr_i != RCR_OFS_CONV6
		&& raddr_i != RCR_OFS_LREG2 |=> rdata_o == '0)
		else $error("unmapped read not zero");
	chk_res_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		raddr_i == RCR_OFS_LREG2 |=> (rdata_o & ~RCR_WMASK) == '0)
		else $error("reserved bits nonzero");
	chk_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		((state_ff.ctrl[0] | state_ff.ctrl[1] | state_ff.ctrl[2]) & ~RCR_WMASK) == '0)
		else $error("reserved bits stored");

	// main scenarios
	cov_sleep: cover property (@(posedge clk_i) disable iff (!rst_n_i) use_sleep_o[1]);
	cov_off: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		pin_enable_i[2] && !rail_on_o[2]);
	cov_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i.we && req_i.addr == RCR_OFS_LREG2);
	cov_pwm: cover property (@(posedge clk_i) disable iff (!rst_n_i) forced_pwm_o[1]);
	cov_lreg_sleep: cover property (@(posedge clk_i) disable iff (!rst_n_i) use_sleep_o[2]);
endmodule : rcr_regs
`default_nettype wire

//--- rcr_pkg.sv
/*
 * rcr_pkg: shared constants and types for the regulator control register bank.
 * Assumes an internal register port (address, write strobe, data) from the
 * serial management front end, which sits outside this bank.
 */
`default_nettype none
package rcr_pkg;
	localparam int RCR_AW = 8;
	localparam int RCR_DW = 8;
	localparam logic [7:0] RCR_OFS_CONV5 = 8'h26;
	localparam logic [7:0] RCR_OFS_CONV6 = 8'h27;
	localparam logic [7:0] RCR_OFS_LREG2 = 8'h28;
	localparam int RCR_NREG = 3;
	localparam int RCR_BIT_FORCE_OFF_N = 0;
	localparam int RCR_BIT_OP_MODE = 1;
	localparam int RCR_SLP_LO = 4;
	localparam int RCR_SLP_HI = 5;
	localparam int RCR_VCODE_W = 7;
	localparam logic [1:0] RCR_SLP_OFF = 2'h0;
	localparam logic [1:0] RCR_SLP_ON = 2'h3;
	// writable bits per register: 7:6 read as zero
	localparam logic [7:0] RCR_WMASK = 8'h3F;
	// factory defaults, arbitrary values standing in for the variant table
	localparam logic [7:0] RCR_RST_CONV5 = 8'h0F;
	localparam logic [7:0] RCR_RST_CONV6 = 8'h0D;
	localparam logic [7:0] RCR_RST_LREG2 = 8'h0D;

	typedef struct packed {
		logic we;
		logic [RCR_AW-1:0] addr;
		logic [RCR_DW-1:0] wdata;
	} rcr_req_t;

	typedef struct packed {
		logic [RCR_VCODE_W-1:0] normal_vcode;
		logic [RCR_VCODE_W-1:0] sleep_vcode;
	} rcr_vcodes_t;
endpackage : rcr_pkg
`default_nettype wire

//--- rcr_rail_sel.sv
/*
 * rcr_rail_sel: per-rail output decode from one control register byte.
 * Assumes the sleep level is already synchronised to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module rcr_rail_sel
	import rcr_pkg::*;
#(
	parameter bit HAS_MODE = 1'b1
) (
	input wire logic [RCR_DW-1:0] ctrl_i,
	input wire logic sleep_n_i,
	input wire logic pin_enable_i,
	input wire rcr_vcodes_t vcodes_i,
	output logic rail_on_o,
	output logic forced_pwm_o,
	output logic use_sleep_o,
	output logic [RCR_VCODE_W-1:0] vcode_o
);
	logic [1:0] slp;
	assign slp = ctrl_i[RCR_SLP_HI:RCR_SLP_LO];
	// 00 ignores the pin; reserved codes also treated as disabled
	assign use_sleep_o = (slp == RCR_SLP_ON) && !sleep_n_i;
	assign vcode_o = use_sleep_o ? vcodes_i.sleep_vcode : vcodes_i.normal_vcode;
	assign rail_on_o = pin_enable_i && ctrl_i[RCR_BIT_FORCE_OFF_N];
	assign forced_pwm_o = HAS_MODE ? ctrl_i[RCR_BIT_OP_MODE] : 1'b0;
endmodule : rcr_rail_sel
`default_nettype wire

//--- tb_top.sv
/* tb_top: random and corner tests of the rcr_regs register bank and rail decode.
   assumes rcr_pkg is compiled first; the bench drives every port of the bank itself. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rcr_pkg::*;
	localparam logic [2:0] SEL = 3'h2;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	rcr_req_t req_i = '0;
	logic [7:0] raddr_i = 8'h00;
	logic [7:0] rdata_o;
	logic s1 = 1'b1;
	logic s2 = 1'b1;
	logic [2:0] pen = 3'h0;
	rcr_vcodes_t [2:0] vc = '0;
	logic [2:0] on_o, pwm_o, slp_o;
	logic [2:0][6:0] vc_o;
	logic [7:0] m [3];
	logic [7:0] d;
	logic [7:0] wv;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	rcr_regs #(.SLEEP_PIN_SEL(SEL)) rcr_regs_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.req_i(req_i), .raddr_i(raddr_i), .rdata_o(rdata_o), .sleep_input_one_n_i(s1),
		.sleep_input_two_n_i(s2), .pin_enable_i(pen), .vcodes_i(vc), .rail_on_o(on_o),
		.forced_pwm_o(pwm_o), .use_sleep_o(slp_o), .vcode_o(vc_o));
	always #20 clk_i = ~clk_i;
	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string s);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i) req_i <= '{we: 1'b1, addr: a, wdata: v};
		@(posedge clk_i) req_i.we <= 1'b0;
		if (a >= RCR_OFS_CONV5 && a <= RCR_OFS_LREG2) m[a - RCR_OFS_CONV5] = v & RCR_WMASK;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i) raddr_i <= a;
		@(posedge clk_i);
		#1 chk({2'h0, rdata_o}, {2'h0, e}, "read data");
	endtask : rd
	function automatic logic [9:0] exp_rail(input int g);
		logic sl;
		sl = m[g][RCR_SLP_HI:RCR_SLP_LO] == RCR_SLP_ON && !(SEL[g] ? s2 : s1);
		exp_rail = {pen[g] & m[g][RCR_BIT_FORCE_OFF_N], g < 2 && m[g][RCR_BIT_OP_MODE], sl,
			sl ? vc[g].sleep_vcode : vc[g].normal_vcode};
	endfunction : exp_rail
	task automatic model_reset();
		m[0] = RCR_RST_CONV5 & RCR_WMASK;
		m[1] = RCR_RST_CONV6 & RCR_WMASK;
		m[2] = RCR_RST_LREG2 & RCR_WMASK;
	endtask : model_reset
	task automatic rails();
		logic [9:0] got;
		repeat (3) @(posedge clk_i);
		#1;
		for (int g = 0; g < 3; g++) begin
			got = {on_o[g], pwm_o[g], slp_o[g], vc_o[g]};
			chk(got, exp_rail(g), "rail");
		end
	endtask : rails
	initial begin
		d = 8'($urandom(32'hFB1F7943));
		model_reset();
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int g = 0; g < 3; g++) rd(RCR_OFS_CONV5 + 8'(g), m[g]);
		wr(RCR_OFS_CONV5, 8'hFF);
		wr(8'h29, 8'h00);
		rd(8'h29, 8'h00);
		rd(RCR_OFS_CONV5, 8'h3F);
		repeat (40) begin
			@(posedge clk_i) pen <= 3'($urandom);
			vc <= 42'({$urandom, $urandom});
			d = 8'($urandom);
			s1 <= d[0];
			s2 <= d[1];
			for (int g = 0; g < 3; g++) begin
				d = 8'($urandom);
				// only sleep codes 00 and 11, reserved bits 7:6 random so the write mask is exercised
				wv = {d[7:6], {2{d[5]}}, g < 2 ? {2'h3, d[1]} : 3'h6, d[0]};
				wr(RCR_OFS_CONV5 + 8'(g), wv);
			end
			rails();
			for (int g = 0; g < 3; g++) rd(RCR_OFS_CONV5 + 8'(g), m[g]);
		end
		// reset in mid-run brings back the factory bytes
		@(posedge clk_i) rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		model_reset();
		rails();
		for (int g = 0; g < 3; g++) rd(RCR_OFS_CONV5 + 8'(g), m[g]);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
